//--- core/fdse_core.sv
// Float divide and word-to-dword sign extend execution datapath
//
// Functional notes
// - Divide first source by second, write quotient
// - Wide divide takes immediate or register operands
// - Register-operand divide behaves like binary divide
// - Zero divisor: error flags, code 0E19
// - Quotient overflow sets carry flag
// - Quotient underflow sets borrow flag
// - Zero quotient sets zero flag
// - Word move copies source into low half
// - Word move replicates sign into high half
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Timing at a glance, counted in sys_clk edges after the issue edge:
//   word_to_dword_move  done and dest_write one edge later
//   zero divisor        done one edge later, destination and arithmetic flags kept
//   float divide        busy from edge 1, done and dest_write at edge 28
// Issue is ignored while busy; the sequencer waits for done before the next one.
// Quotients are truncated, not rounded, to keep the divider to one subtractor.
// Denormal operands are taken as zero; a zero dividend gives a signed zero.
// Register port indices: 0 status, 1 mask, 2 error code, 3 error latch.
// Status bits, low to high: zero, borrow, carry, operation error.
module fdse_core (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 arst_n,
  // Instruction issue from the sequencer
  input  wire logic                 issue,
  input  wire fdse_pkg::fdse_op_type op,
  input  wire logic                 src1_is_imm,
  input  wire logic                 src2_is_imm,
  input  wire logic [31:0]          src1_imm,
  input  wire logic [31:0]          src2_imm,
  input  wire logic [15:0]          src1_lo,
  input  wire logic [15:0]          src1_hi,
  input  wire logic [15:0]          src2_lo,
  input  wire logic [15:0]          src2_hi,
  input  wire logic [15:0]          move_src,
  // Result to the destination register pair
  output logic                      busy,
  output logic                      done,
  output logic                      dest_write,
  output logic [15:0]               dest_lo,
  output logic [15:0]               dest_hi,
  // Status flags and error report
  output logic                      zero_flag,
  output logic                      borrow_flag,
  output logic                      carry_flag,
  output logic                      operation_error_flag,
  output logic                      operation_error_latch,
  output logic [15:0]               error_code_register,
  // Software interrupt port
  input  wire logic [3:0]           reg_addr,
  input  wire logic [15:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [15:0]               reg_rdata,
  output logic                      irq
);

  // Register indices of the interrupt port
  localparam logic [3:0] ADDR_STAT = 4'h0;
  localparam logic [3:0] ADDR_MASK = 4'h1;
  localparam logic [3:0] ADDR_ERR  = 4'h2;
  localparam logic [3:0] ADDR_LAT  = 4'h3;

  // Operand selection: register pair joins low word under high word
  wire        is_div   = (op == fdse_pkg::FDSE_OP_DIV) || (op == fdse_pkg::FDSE_OP_DIV32);
  wire        use_imm1 = (op == fdse_pkg::FDSE_OP_DIV) || src1_is_imm;
  wire        use_imm2 = (op == fdse_pkg::FDSE_OP_DIV) || src2_is_imm;
  wire [31:0] a_val    = use_imm1 ? src1_imm : {src1_hi, src1_lo};
  wire [31:0] b_val    = use_imm2 ? src2_imm : {src2_hi, src2_lo};

  // Operand fields
  wire        a_sign = a_val[fdse_pkg::FDSE_SIGN_POS];
  wire        b_sign = b_val[fdse_pkg::FDSE_SIGN_POS];
  wire [7:0]  a_exp  = a_val[30:fdse_pkg::FDSE_EXP_POS];
  wire [7:0]  b_exp  = b_val[30:fdse_pkg::FDSE_EXP_POS];
  wire        a_zero = (a_exp == 8'h00);
  wire        b_zero = (b_exp == 8'h00);
  wire [23:0] a_man  = {1'b1, a_val[22:0]};
  wire [23:0] b_man  = {1'b1, b_val[22:0]};
  // Biased exponent of quotient, kept signed and wide to catch range faults
  wire signed [10:0] exp_start = $signed({3'h0, a_exp}) - $signed({3'h0, b_exp})
                                 + $signed({3'h0, fdse_pkg::FDSE_EXP_BIAS});
  // Sign-extended move result
  wire [31:0] move_val = {{16{move_src[15]}}, move_src};

  // Issue decode: a request counts only while the divider is idle
  wire        take      = issue && !busy;
  wire        is_move   = (op == fdse_pkg::FDSE_OP_MOVEXT);
  wire        take_move = take && is_move;
  wire        take_zero = take && is_div && b_zero;
  wire        take_div  = take && is_div && !b_zero;

  // Divider state
  fdse_pkg::fdse_state_type state_reg;
  logic [4:0]         step_reg;
  logic [25:0]        rem_reg;
  logic [23:0]        div_reg;
  logic [25:0]        quo_reg;
  logic signed [10:0] exp_reg;
  logic               sign_reg;
  logic               num_zero_reg;

  // Restoring division step: one quotient bit per clock
  wire [25:0] rem_sub  = rem_reg - {2'h0, div_reg};
  wire        rem_ge   = (rem_reg >= {2'h0, div_reg});
  wire [25:0] rem_step = rem_ge ? rem_sub : rem_reg;
  wire [25:0] quo_step = {quo_reg[24:0], rem_ge};

  // Normalise: the ratio lies in (0.5, 2), so at most one shift is needed
  wire               quo_top  = quo_reg[25];
  wire [22:0]        frac_n   = quo_top ? quo_reg[24:2] : quo_reg[23:1];
  wire signed [10:0] exp_n    = quo_top ? exp_reg : exp_reg - 11'sd1;
  // Truncation keeps the datapath small; no rounding to nearest
  // A zero dividend is an exact zero, never a range fault, whatever the exponents say
  wire               exp_hi   = exp_n >= $signed({3'h0, fdse_pkg::FDSE_EXP_MAX});
  wire               exp_lo   = exp_n <= 11'sd0;
  wire               ovf      = !num_zero_reg && exp_hi;
  wire               unf      = !num_zero_reg && exp_lo;
  wire               res_zero = num_zero_reg || unf;
  wire [31:0]        quo_val  = res_zero ? {sign_reg, 31'h0}
                              : ovf ? {sign_reg, fdse_pkg::FDSE_EXP_MAX, 23'h0}
                              : {sign_reg, exp_n[7:0], frac_n};

  // Interrupt port decode
  logic [3:0] stat_reg;
  logic [3:0] mask_reg;
  wire        wr_stat  = reg_wr && (reg_addr == ADDR_STAT);
  wire        wr_mask  = reg_wr && (reg_addr == ADDR_MASK);
  wire        wr_lat   = reg_wr && (reg_addr == ADDR_LAT);
  wire        lat_clr  = wr_lat && reg_wdata[0];
  wire        fin      = (state_reg == fdse_pkg::FDSE_ST_FIN);
  wire        div_err  = take_zero;
  wire [3:0]  events   = {div_err, fin && ovf, fin && unf, fin && res_zero};
  // Hardware set wins over a write-one clear in the same cycle
  wire [3:0]  stat_next = (stat_reg & ~(wr_stat ? reg_wdata[3:0] : 4'h0)) | events;
  // A new mask already counts in the cycle it is written
  wire [3:0]  mask_next = wr_mask ? reg_wdata[3:0] : mask_reg;
  wire        irq_next  = |(stat_next & mask_next);
  logic [15:0] rd_mux;
  wire [15:0] rd_next   = reg_rd ? rd_mux : 16'h0000;

  // Read selection; indices outside the map read as zero
  always_comb
  begin
    if (reg_addr == ADDR_STAT)
    begin
      rd_mux = {12'h000, stat_reg};
    end
    else if (reg_addr == ADDR_MASK)
    begin
      rd_mux = {12'h000, mask_reg};
    end
    else if (reg_addr == ADDR_ERR)
    begin
      rd_mux = error_code_register;
    end
    else if (reg_addr == ADDR_LAT)
    begin
      rd_mux = {15'h0000, operation_error_latch};
    end
    else
    begin
      rd_mux = 16'h0000;
    end
  end

  // Divider sequence and result writing
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg    <= fdse_pkg::FDSE_ST_IDLE;
      step_reg     <= 5'h00;
      rem_reg      <= 26'h0000000;
      div_reg      <= 24'h000000;
      quo_reg      <= 26'h0000000;
      exp_reg      <= 11'sd0;
      sign_reg     <= 1'b0;
      num_zero_reg <= 1'b0;
      busy         <= 1'b0;
      done         <= 1'b0;
      dest_write   <= 1'b0;
      dest_lo      <= 16'h0000;
      dest_hi      <= 16'h0000;
    end
    else
    begin
      done       <= 1'b0;
      dest_write <= 1'b0;
      case (state_reg)
        fdse_pkg::FDSE_ST_IDLE:
        begin
          if (take_move)
          begin
            dest_lo    <= move_val[15:0];
            dest_hi    <= move_val[31:16];
            dest_write <= 1'b1;
            done       <= 1'b1;
          end
          else if (take_zero)
          begin
            done <= 1'b1; // destination left untouched
          end
          else if (take_div)
          begin
            rem_reg      <= {2'h0, a_man};
            div_reg      <= b_man;
            quo_reg      <= 26'h0000000;
            exp_reg      <= exp_start;
            sign_reg     <= a_sign ^ b_sign;
            num_zero_reg <= a_zero;
            step_reg     <= fdse_pkg::FDSE_DIV_STEPS;
            busy         <= 1'b1;
            state_reg    <= fdse_pkg::FDSE_ST_RUN;
          end
        end
        fdse_pkg::FDSE_ST_RUN:
        begin
          rem_reg  <= {rem_step[24:0], 1'b0};
          quo_reg  <= quo_step;
          step_reg <= step_reg - 5'h01;
          if (step_reg == 5'h01)
          begin
            state_reg <= fdse_pkg::FDSE_ST_FIN;
          end
        end
        fdse_pkg::FDSE_ST_FIN:
        begin
          dest_lo    <= quo_val[15:0];
          dest_hi    <= quo_val[31:16];
          dest_write <= 1'b1;
          done       <= 1'b1;
          busy       <= 1'b0;
          state_reg  <= fdse_pkg::FDSE_ST_IDLE;
        end
        default:
        begin
          state_reg <= fdse_pkg::FDSE_ST_IDLE;
        end
      endcase
    end
  end

  // Arithmetic flags follow each divide that writes a quotient and hold over moves and zero-divisor divides
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      zero_flag   <= 1'b0;
      borrow_flag <= 1'b0;
      carry_flag  <= 1'b0;
    end
    else if (fin)
    begin
      zero_flag   <= res_zero;
      borrow_flag <= unf;
      carry_flag  <= ovf;
    end
  end

  // Error flag tracks the last divide issue; a good divide clears it
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      operation_error_flag <= 1'b0;
    end
    else if (take_div || take_zero)
    begin
      operation_error_flag <= take_zero;
    end
  end

  // Error latch and code are sticky; a new error wins over a clear
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      operation_error_latch <= 1'b0;
      error_code_register   <= fdse_pkg::FDSE_ERR_RESET;
    end
    else if (div_err)
    begin
      operation_error_latch <= 1'b1;
      error_code_register   <= fdse_pkg::FDSE_ERR_DIV_ZERO;
    end
    else if (lat_clr)
    begin
      operation_error_latch <= 1'b0;
    end
  end

  // Interrupt status: sticky event bits, cleared by writing ones
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stat_reg <= 4'h0;
    end
    else
    begin
      stat_reg <= stat_next;
    end
  end

  // Interrupt mask, same layout as the status bits
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mask_reg <= 4'h0;
    end
    else if (wr_mask)
    begin
      mask_reg <= reg_wdata[3:0];
    end
  end

  // Level interrupt, registered so the pin comes straight from a flip-flop
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= irq_next;
    end
  end

  // Read data stand only in the cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_rdata <= 16'h0000;
    end
    else
    begin
      reg_rdata <= rd_next;
    end
  end

endmodule : fdse_core
`default_nettype wire

//--- core/fdse_pkg.sv
// Package: constants and types for the float divide and sign extend datapath
package fdse_pkg;
  // Opcodes presented by the sequencer
  typedef enum logic [1:0] {
    FDSE_OP_NONE   = 2'b00,
    FDSE_OP_DIV    = 2'b01,
    FDSE_OP_DIV32  = 2'b10,
    FDSE_OP_MOVEXT = 2'b11
  } fdse_op_type;
  // Divider state machine
  typedef enum logic [1:0] {
    FDSE_ST_IDLE = 2'b00,
    FDSE_ST_RUN  = 2'b01,
    FDSE_ST_FIN  = 2'b10
  } fdse_state_type;
  localparam logic [15:0] FDSE_ERR_DIV_ZERO = 16'h0E19;
  localparam logic [15:0] FDSE_ERR_RESET    = 16'h0000;
  localparam logic [31:0] FDSE_WORD_RESET   = 32'h00000000;
  localparam logic [7:0]  FDSE_EXP_BIAS     = 8'h7F;
  localparam logic [7:0]  FDSE_EXP_MAX      = 8'hFF;
  localparam logic [4:0]  FDSE_DIV_STEPS    = 5'h1A;
  localparam int          FDSE_EXP_POS      = 23;
  localparam int          FDSE_SIGN_POS     = 31;
endpackage : fdse_pkg

//--- verif/fdse_core_sva.sv
// Concurrent checks on the divide and sign extend datapath
`timescale 1ns/1ps
`default_nettype none
module fdse_core_sva (
  // Clock, reset and issue side
  input wire logic sys_clk, arst_n, issue, busy, src2_is_imm, reg_rd,
  input wire fdse_pkg::fdse_op_type op,
  input wire logic [31:0] src2_imm,
  input wire logic [15:0] src2_hi, move_src, error_code_register,
  input wire logic [3:0] reg_addr,
  // Results and flags
  input wire logic done, dest_write, zero_flag, borrow_flag, carry_flag,
  input wire logic operation_error_flag, operation_error_latch,
  input wire logic [15:0] dest_lo, dest_hi, reg_rdata
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Taken requests; the divisor exponent follows the operand source that the op selects
  wire logic take = issue && !busy;
  wire logic dv = take && (op == fdse_pkg::FDSE_OP_DIV || op == fdse_pkg::FDSE_OP_DIV32);
  wire logic mv = take && op == fdse_pkg::FDSE_OP_MOVEXT;
  wire logic regs = op == fdse_pkg::FDSE_OP_DIV32 && !src2_is_imm;
  wire logic [7:0] dexp = regs ? src2_hi[14:7] : src2_imm[30:23];
  wire logic qz = dest_lo == 16'h0000 && dest_hi[14:0] == 15'h0000;
  a_move_sign: assert property (mv |=> done && dest_write && dest_hi == {16{$past(move_src[15])}})
    else $error("move high word not sign filled");
  a_move_low: assert property (mv |=> dest_lo == $past(move_src))
    else $error("move low word wrong");
  a_div_latency: assert property (dv && dexp != 8'h00 |=> busy [*8] ##19 busy ##1 done && dest_write && !busy)
    else $error("divide result not on time");
  a_zero_divisor: assert property (dv && dexp == 8'h00 |=> done && !dest_write && operation_error_flag && operation_error_latch && error_code_register == 16'h0E19)
    else $error("zero divisor not reported");
  a_zero_flag: assert property (done && dest_write && $past(busy) && qz |-> zero_flag)
    else $error("zero quotient without zero flag");
  a_carry_flag: assert property (done && dest_write && $past(busy) && dest_hi[14:7] == 8'hFF |-> carry_flag)
    else $error("overflow without carry flag");
  a_borrow_zero: assert property (done && dest_write && $past(busy) && borrow_flag |-> zero_flag && qz)
    else $error("borrow flag without zero quotient");
  a_code_read: assert property (reg_rd && reg_addr == 4'h2 |=> reg_rdata == $past(error_code_register))
    else $error("error code read back wrong");
  // Main scenarios reached
  c_move: cover property (mv);
  c_zero_div: cover property (dv && dexp == 8'h00);
  c_carry: cover property (done && carry_flag);
endmodule : fdse_core_sva
bind fdse_core fdse_core_sva i_fdse_core_sva (.*);
`default_nettype wire

//--- verif/fdse_regfile_model.sv
// Operand data register file on the sequencer side
`timescale 1ns/1ps
`default_nettype none
module fdse_regfile_model (
  // Clock and loading port
  input wire logic        sys_clk,
  input wire logic        ld,
  input wire logic [1:0]  ld_idx,
  input wire logic [15:0] ld_data,
  // Operand register pairs
  output logic [15:0]     src1_lo,
  output logic [15:0]     src1_hi,
  output logic [15:0]     src2_lo,
  output logic [15:0]     src2_hi
);
  logic [15:0] mem [4];
  // One data register loaded per cycle, as the sequencer would
  always_ff @(posedge sys_clk)
    if (ld)
      mem[ld_idx] <= ld_data;
  // Low half in the lower-numbered register of each pair
  assign {src1_hi, src1_lo, src2_hi, src2_lo} = {mem[1], mem[0], mem[3], mem[2]};
endmodule : fdse_regfile_model
`default_nettype wire

//--- verif/fdse_core_tb.sv
// Self-checking bench for the divide and sign extend datapath
`timescale 1ns/1ps
`default_nettype none
module fdse_core_tb;
  logic sys_clk = 0, arst_n = 0, issue = 0, src1_is_imm = 0, src2_is_imm = 0;
  logic reg_wr = 0, reg_rd = 0, ld = 0, rd_q = 0, mix = 0;
  logic busy, done, dest_write, zero_flag, borrow_flag, carry_flag, irq;
  logic operation_error_flag, operation_error_latch;
  fdse_pkg::fdse_op_type op = fdse_pkg::FDSE_OP_NONE;
  logic [31:0] src1_imm = 0, src2_imm = 0, ra, rb, r2;
  logic [15:0] src1_lo, src1_hi, src2_lo, src2_hi, dest_lo, dest_hi, reg_rdata;
  logic [15:0] move_src = 0, reg_wdata = 0, ld_data = 0, error_code_register;
  logic [3:0] reg_addr = 0;
  logic [1:0] ld_idx = 0;
  logic [35:0] last = 0, res_q [$];
  logic [15:0] rd_exp [$];
  logic [31:0] ta [4] = '{32'hC0C00000, 32'hFF000000, 32'h00800000, 32'h00000000};
  logic [31:0] tb [4] = '{32'h40000000, 32'h00800000, 32'hFF000000, 32'h40000000};
  logic [35:0] tx [4] = '{36'hC04000000, 36'hFF8000002, 36'h80000000C, 36'h000000008};
  int errors = 0, cmp_count = 0, seed = 58;
  fdse_core i_fdse_core (.*);
  fdse_regfile_model i_fdse_regfile_model (.*);
  initial forever #20 sys_clk = ~sys_clk;
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    if (errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run
  // One-cycle register strobe; the caller's next access may follow with no gap
  task automatic reg_op(input logic w, input logic [3:0] a, input logic [15:0] d);
    if (!w)
      rd_exp.push_back(d);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
  endtask : reg_op
  // Loads the operand pairs when rf is set, issues one instruction and waits for done under a bound
  task automatic run(input logic [1:0] o, input logic [31:0] a, b, input logic rf,
                     input logic [35:0] e);
    logic [63:0] w;
    w = {b, a};
    reg_wr <= 0;
    reg_rd <= 0;
    for (int i = 0; i < 4; i++)
    begin
      ld <= rf;
      ld_idx <= i[1:0];
      ld_data <= w[16 * i +: 16];
      @(posedge sys_clk);
    end
    res_q.push_back(e);
    last = e;
    ld <= 0;
    op <= fdse_pkg::fdse_op_type'(o);
    src1_is_imm <= !rf || mix; // Mixed form: first operand immediate
    src2_is_imm <= !rf;
    src1_imm <= (rf && !mix) ? ~a : a; // Register operands get poisoned immediates
    src2_imm <= rf ? ~b : b;
    issue <= 1;
    @(posedge sys_clk);
    issue <= 0;
    repeat (40)
    begin
      @(posedge sys_clk);
      if (done === 1'b1)
        break;
    end
    if (done !== 1'b1)
      errors++;
  endtask : run
  // Results are judged against the oldest note; read data lag the strobe by one cycle
  always @(posedge sys_clk)
  begin
    if (done === 1'b1)
      check({dest_hi, dest_lo, zero_flag, borrow_flag, carry_flag, operation_error_flag},
            res_q.pop_front());
    if (rd_q)
      check({20'h00000, reg_rdata}, {20'h00000, rd_exp.pop_front()});
    rd_q <= reg_rd;
  end
  initial
  begin
    repeat (16) @(posedge sys_clk);
    arst_n <= 1;
    for (int i = 0; i < 4; i++)
      reg_op(0, i[3:0], 16'h0000);
    reg_op(1, 4'h1, 16'h000F);
    for (int f = 0; f < 3; f++)
      for (int i = 0; i < 4; i++)
        run(f == 0 ? 2'd1 : 2'd2, ta[i], tb[i], f == 2, tx[i]);
    for (int i = 0; i < 24; i++)
    begin
      r2 = $random(seed);
      ra = $random(seed);
      ra[30:23] = 8'h50 + {2'b00, ra[28:23]};
      rb = {r2[31], 8'h60 + {2'b00, r2[21:16]}, 23'h000000};
      mix = r2[7];
      run(r2[9] ? 2'd2 : 2'd1, ra, rb, r2[9] & r2[8],
          {ra[31] ^ rb[31], ra[30:23] - rb[30:23] + 8'h7F, ra[22:0], 4'h0});
      move_src <= r2[15:0];
      run(2'd3, ra, rb, 0, {{16{r2[15]}}, r2[15:0], last[3:0]});
    end
    mix = 0;
    run(2'd1, 32'h40400000, 32'h00000001, 0, {last[35:1], 1'b1});
    run(2'd2, 32'h40400000, 32'h00000000, 1, {last[35:1], 1'b1});
    reg_op(0, 4'h2, 16'h0E19);
    reg_op(0, 4'h3, 16'h0001);
    reg_op(0, 4'h0, 16'h000F);
    check({35'h0, irq}, 36'h1);
    reg_op(1, 4'h0, 16'h000F);
    reg_op(1, 4'h3, 16'h0001);
    reg_op(0, 4'h0, 16'h0000);
    reg_op(0, 4'h3, 16'h0000);
    reg_op(0, 4'h2, 16'h0E19);
    reg_op(0, 4'hF, 16'h0000);
    check({35'h0, irq}, 36'h0);
    reg_op(1, 4'h1, 16'h0000);
    run(2'd1, 32'h40400000, 32'h00000000, 0, {last[35:1], 1'b1});
    check({35'h0, irq}, 36'h0);
    reg_op(1, 4'h1, 16'h0008);
    reg_op(0, 4'h1, 16'h0008);
    reg_op(0, 4'h0, 16'h0008);
    reg_op(0, 4'h2, 16'h0E19);
    check({35'h0, irq}, 36'h1);
    reg_rd <= 0;
    reg_wr <= 0;
    repeat (3) @(posedge sys_clk);
    complete_run();
  end
  // Watchdog well beyond the fewer than 1500 cycles the sequence needs
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    complete_run();
  end
endmodule : fdse_core_tb
`default_nettype wire
